// >>> verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
	// ==========================
	// register byte offsets
	localparam logic [7:0] OFS_INT = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_CHAN_RANGE = 8'h10;
	localparam logic [7:0] OFS_START_CONV = 8'h24;
	localparam logic [7:0] OFS_GAIN0 = 8'h40;
	localparam int GAIN_REGS = 4;
	// ==========================
	// field positions
	localparam int INT_ENABLE_BIT = 0;
	localparam int INT_PENDING_BIT = 1;
	localparam int INT_RELEASE_BIT = 15;
	localparam int CTRL_SE_BIT = 3;
	localparam int CTRL_SCAN_LSB = 8;
	localparam int CTRL_IRQ_LSB = 12;
	localparam int RANGE_START_LSB = 0;
	localparam int RANGE_END_LSB = 8;
	localparam int START_CONV_BIT = 0;
	// ==========================
	// reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] RANGE_RESET = 16'h0000;
	localparam logic [15:0] GAIN_RESET = 16'h0000;
	// ==========================
	// sizes
	localparam int DATA_W = 16;
	localparam int CHAN_W = 5;
	localparam logic [4:0] DIFF_MASK = 5'h0f;

	typedef enum logic [2:0] {
		SCAN_OFF = 3'b000,
		SCAN_UNI_CONT = 3'b001,
		SCAN_UNI_SINGLE = 3'b010,
		SCAN_BURST_CONT = 3'b011,
		SCAN_BURST_SINGLE = 3'b100,
		SCAN_EXT_ONLY = 3'b101
	} scan_mode_t;

	typedef enum logic [1:0] {
		IRQ_NONE = 2'b00,
		IRQ_PER_CHAN = 2'b01,
		IRQ_PER_GROUP = 2'b10
	} irq_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_FLUSH = 2'b10,
		ST_DRAIN = 2'b11
	} seq_state_t;
endpackage

// >>> verilog/channel_pointer.sv
`timescale 1ns/1ps
module channel_pointer
	import adc_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// control
	input wire logic load,
	input wire logic advance,
	input wire logic [4:0] start_ch,
	input wire logic [4:0] end_ch,
	input wire logic single_ended,
	input wire logic [63:0] gain_bits,
	// pointer and analog front end
	output logic [4:0] cur_chan,
	output logic at_end,
	output logic [4:0] mux_pos,
	output logic [3:0] mux_neg,
	output logic mux_sense,
	output logic [1:0] gain_sel
);
	logic [4:0] next_cur_chan;

	// differential mode only has 16 channels
	function automatic logic [4:0] clamp_ch(input logic [4:0] ch, input logic se);
		clamp_ch = se ? ch : (ch & DIFF_MASK);
	endfunction

	assign at_end = (cur_chan == clamp_ch(end_ch, single_ended));

	// ==========================
	// pointer
	always_comb begin
		next_cur_chan = cur_chan;
		if (load) begin
			next_cur_chan = clamp_ch(start_ch, single_ended);
		end else if (advance) begin
			// wrap to start so continuous scans cycle round robin
			next_cur_chan = at_end ? clamp_ch(start_ch, single_ended) : cur_chan + 5'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cur_chan <= 5'h00;
			mux_pos <= 5'h00;
			mux_neg <= 4'h0;
			mux_sense <= 1'b1;
			gain_sel <= 2'h0;
		end else begin
			cur_chan <= next_cur_chan;
			// a pointer left above 15 by a single-ended scan must not reach the plus mux
			mux_pos <= clamp_ch(next_cur_chan, single_ended);
			mux_neg <= next_cur_chan[3:0];
			mux_sense <= single_ended;
			gain_sel <= gain_bits[{next_cur_chan, 1'b0} +: 2];
		end
	end

	// ==========================
	// checks
	chk_diff_range: assert property (@(posedge clock) disable iff (!rst_b)
		!single_ended && !load |=> mux_pos[4] == 1'b0)
		else $error("differential channel above 15");
	chk_gain_follow: assert property (@(posedge clock) disable iff (!rst_b)
		advance && !load |=> gain_sel == gain_bits[{cur_chan, 1'b0} +: 2])
		else $error("gain does not follow channel");
endmodule

// >>> verilog/adc_scan_interrupt_control.sv
`timescale 1ns/1ps
module adc_scan_interrupt_control
	import adc_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// interrupt line, open drain
	output logic inta_o,
	output logic inta_oe,
	// converter
	input wire logic pace_tick,
	input wire logic result_valid,
	input wire logic [15:0] result_data,
	output logic conv_start,
	// analog front end
	output logic [4:0] mux_pos,
	output logic [3:0] mux_neg,
	output logic mux_sense,
	output logic [1:0] gain_sel,
	// mailbox
	output logic mbox_wr,
	output logic [4:0] mbox_chan,
	output logic [15:0] mbox_data,
	output logic [31:0] new_data_set
);
	logic int_enable, next_int_enable;
	logic pending, next_pending;
	logic [15:0] ctrl, next_ctrl;
	logic [15:0] chan_range, next_chan_range;
	logic [15:0] gain [GAIN_REGS];
	logic [15:0] next_gain [GAIN_REGS];
	logic [15:0] next_reg_rdata;
	seq_state_t state, next_state;
	logic started, next_started;
	logic prev_valid, next_prev_valid;
	logic [4:0] conv_chan, next_conv_chan;
	logic [4:0] held_chan, next_held_chan;
	logic next_conv_start, next_mbox_wr;
	logic [4:0] next_mbox_chan;
	logic [15:0] next_mbox_data;
	logic [31:0] next_new_data_set;
	logic [4:0] cur_chan, start_ch, end_ch;
	logic at_end, ptr_load, ptr_advance, single_ended;
	logic release_wr, start_wr, irq_event, last_written;
	scan_mode_t scan_mode;
	irq_mode_t irq_mode;
	logic [63:0] gain_bits;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign scan_mode = scan_mode_t'(ctrl[CTRL_SCAN_LSB +: 3]);
	assign irq_mode = irq_mode_t'(ctrl[CTRL_IRQ_LSB +: 2]);
	assign single_ended = ctrl[CTRL_SE_BIT];
	assign start_ch = chan_range[RANGE_START_LSB +: CHAN_W];
	assign end_ch = chan_range[RANGE_END_LSB +: CHAN_W];
	assign release_wr = reg_wr && hit(reg_addr, OFS_INT) && reg_wdata[INT_RELEASE_BIT];
	assign start_wr = reg_wr && hit(reg_addr, OFS_START_CONV) && reg_wdata[START_CONV_BIT];

	// ==========================
	// registers
	genvar gi;
	generate
		for (gi = 0; gi < GAIN_REGS; gi++) begin : g_gain
			assign gain_bits[gi*16 +: 16] = gain[gi];
			always_comb begin
				next_gain[gi] = gain[gi];
				if (reg_wr && hit(reg_addr, OFS_GAIN0 + 8'(gi*4))) begin
					next_gain[gi] = reg_wdata;
				end
			end
			always_ff @(posedge clock) begin
				if (!rst_b) begin
					gain[gi] <= GAIN_RESET;
				end else begin
					gain[gi] <= next_gain[gi];
				end
			end
		end
	endgenerate

	always_comb begin
		next_int_enable = int_enable;
		next_ctrl = ctrl;
		next_chan_range = chan_range;
		next_reg_rdata = reg_rdata;
		if (reg_wr && hit(reg_addr, OFS_INT)) begin
			next_int_enable = reg_wdata[INT_ENABLE_BIT];
		end
		if (reg_wr && hit(reg_addr, OFS_CTRL)) begin
			next_ctrl = reg_wdata;
		end
		if (reg_wr && hit(reg_addr, OFS_CHAN_RANGE)) begin
			next_chan_range = reg_wdata;
		end
		if (reg_rd) begin
			next_reg_rdata = 16'h0000;
			case (reg_addr)
				OFS_INT: begin
					next_reg_rdata[INT_ENABLE_BIT] = int_enable;
					next_reg_rdata[INT_PENDING_BIT] = pending;
				end
				OFS_CTRL: next_reg_rdata = ctrl;
				OFS_CHAN_RANGE: next_reg_rdata = chan_range;
				OFS_GAIN0: next_reg_rdata = gain[0];
				OFS_GAIN0 + 8'h04: next_reg_rdata = gain[1];
				OFS_GAIN0 + 8'h08: next_reg_rdata = gain[2];
				OFS_GAIN0 + 8'h0c: next_reg_rdata = gain[3];
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			int_enable <= 1'b0;
			ctrl <= CTRL_RESET;
			chan_range <= RANGE_RESET;
			reg_rdata <= 16'h0000;
		end else begin
			int_enable <= next_int_enable;
			ctrl <= next_ctrl;
			chan_range <= next_chan_range;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ==========================
	// scan sequencer
	// results lag one conversion, so each stored word belongs to held_chan
	assign ptr_load = start_wr && scan_mode != SCAN_OFF;
	assign ptr_advance = next_conv_start && state == ST_RUN;
	assign last_written = next_mbox_wr && held_chan == (single_ended ? end_ch : (end_ch & DIFF_MASK));

	always_comb begin
		next_state = state;
		next_started = started;
		next_prev_valid = prev_valid;
		next_conv_chan = conv_chan;
		next_held_chan = held_chan;
		next_conv_start = 1'b0;
		next_mbox_wr = 1'b0;
		next_mbox_chan = mbox_chan;
		next_mbox_data = mbox_data;
		next_new_data_set = 32'h0;
		case (state)
			ST_IDLE: begin
				if (ptr_load) begin
					next_state = ST_RUN;
					// external-trigger mode keeps the stale first word
					next_started = (scan_mode == SCAN_EXT_ONLY);
					next_prev_valid = 1'b0;
				end
			end
			ST_RUN: begin
				if (scan_mode == SCAN_OFF) begin
					next_state = ST_IDLE;
				end else if (pace_tick) begin
					next_conv_start = 1'b1;
					if (at_end && (scan_mode == SCAN_UNI_SINGLE ||
						scan_mode == SCAN_BURST_SINGLE)) begin
						next_state = ST_FLUSH;
					end
				end
			end
			ST_FLUSH: begin
				// one extra convert pulls the last word out of the converter
				if (pace_tick) begin
					next_conv_start = 1'b1;
					next_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (result_valid) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (next_conv_start) begin
			next_held_chan = conv_chan;
			next_conv_chan = cur_chan;
			next_prev_valid = started;
			next_started = 1'b1;
		end
		if (result_valid && prev_valid && state != ST_IDLE) begin
			next_mbox_wr = 1'b1;
			next_mbox_chan = held_chan;
			next_mbox_data = result_data;
			next_new_data_set = 32'h1 << held_chan;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			started <= 1'b0;
			prev_valid <= 1'b0;
			conv_chan <= 5'h00;
			held_chan <= 5'h00;
			conv_start <= 1'b0;
			mbox_wr <= 1'b0;
			mbox_chan <= 5'h00;
			mbox_data <= 16'h0000;
			new_data_set <= 32'h0;
		end else begin
			state <= next_state;
			started <= next_started;
			prev_valid <= next_prev_valid;
			conv_chan <= next_conv_chan;
			held_chan <= next_held_chan;
			conv_start <= next_conv_start;
			mbox_wr <= next_mbox_wr;
			mbox_chan <= next_mbox_chan;
			mbox_data <= next_mbox_data;
			new_data_set <= next_new_data_set;
		end
	end

	channel_pointer u_ptr (
		.clock(clock),
		.rst_b(rst_b),
		.load(ptr_load),
		.advance(ptr_advance),
		.start_ch(start_ch),
		.end_ch(end_ch),
		.single_ended(single_ended),
		.gain_bits(gain_bits),
		.cur_chan(cur_chan),
		.at_end(at_end),
		.mux_pos(mux_pos),
		.mux_neg(mux_neg),
		.mux_sense(mux_sense),
		.gain_sel(gain_sel)
	);

	// ==========================
	// interrupt
	assign irq_event = int_enable && next_mbox_wr &&
		(irq_mode == IRQ_PER_CHAN || (irq_mode == IRQ_PER_GROUP && last_written));

	always_comb begin
		next_pending = pending;
		if (release_wr) begin
			next_pending = 1'b0;
		end
		// a new event in the release cycle is kept, not lost
		if (irq_event) begin
			next_pending = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pending <= 1'b0;
			inta_oe <= 1'b0;
		end else begin
			pending <= next_pending;
			inta_oe <= next_pending;
		end
	end
	assign inta_o = 1'b0;

	// ==========================
	// checks
	chk_chan_irq: assert property (@(posedge clock) disable iff (!rst_b)
		int_enable && irq_mode == IRQ_PER_CHAN && next_mbox_wr |=> inta_oe)
		else $error("per-channel event did not raise the line");
	chk_line_pending: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(pending) |-> $past(int_enable) && inta_oe && !inta_o)
		else $error("line not driven with request");
	chk_release: assert property (@(posedge clock) disable iff (!rst_b)
		release_wr && !irq_event |=> !pending && !inta_oe)
		else $error("release did not drop request");
	chk_enable_gate: assert property (@(posedge clock) disable iff (!rst_b)
		!int_enable && !pending |=> !pending)
		else $error("request raised while disabled");
	chk_group_only: assert property (@(posedge clock) disable iff (!rst_b)
		irq_mode == IRQ_PER_GROUP && !last_written && !pending |=> !pending)
		else $error("group mode raised before last channel");
	chk_no_scan: assert property (@(posedge clock) disable iff (!rst_b)
		state == ST_IDLE && !pending |=> !pending)
		else $error("request without a running scan");
	chk_pending_read: assert property (@(posedge clock) disable iff (!rst_b)
		reg_rd && reg_addr == OFS_INT |=> reg_rdata[INT_PENDING_BIT] == $past(pending))
		else $error("pending bit wrong");
	chk_level_hold: assert property (@(posedge clock) disable iff (!rst_b)
		pending && !release_wr |=> pending)
		else $error("request dropped without release");
	chk_next_chan: assert property (@(posedge clock) disable iff (!rst_b)
		ptr_advance && start_ch != end_ch && !ptr_load |=> cur_chan != $past(cur_chan))
		else $error("pointer did not move after convert");
	chk_new_data: assert property (@(posedge clock) disable iff (!rst_b)
		new_data_set == (mbox_wr ? (32'h1 << mbox_chan) : 32'h0))
		else $error("new-data flag missing");
endmodule

// >>> dv/adc_front_model.sv
`timescale 1ns/1ps
// ==========================
// converter model: each start returns the word of the conversion before
module adc_front_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// converter side
	input wire logic conv_start,
	input wire logic [4:0] mux_pos,
	input wire logic slow,
	output logic result_valid,
	output logic [15:0] result_data
);
	logic [4:0] prev_mux;
	logic [4:0] held;
	logic [2:0] cnt;
	logic [15:0] word;
	initial begin
		result_valid = 1'b0;
		result_data = 16'h0f0f;
		prev_mux = 5'h00;
		held = 5'h1f;
		cnt = 3'h0;
		word = 16'h0000;
	end
	always @(posedge clock) begin
		prev_mux <= mux_pos;
		result_valid <= 1'b0;
		// stale data toggles so a late sample never looks valid
		result_data <= ~result_data;
		if (!rst_b) begin
			cnt <= 3'h0;
		end else if (conv_start) begin
			word <= {held, ~held, 6'h25};
			held <= prev_mux;
			cnt <= slow ? 3'h4 : 3'h1;
		end else if (cnt == 3'h1) begin
			result_valid <= 1'b1;
			result_data <= word;
			cnt <= 3'h0;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
		end
	end
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import adc_ctrl_pkg::*;
	logic clock, rst_b, reg_wr, reg_rd, pace_tick, slow, result_valid;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, result_data, mbox_data, rdv;
	logic inta_o, inta_oe, conv_start, mux_sense, mbox_wr;
	logic [4:0] mux_pos, mbox_chan;
	logic [3:0] mux_neg;
	logic [1:0] gain_sel, irq_exp;
	logic [31:0] new_data_set;
	logic [63:0] gains;
	logic se_exp, en_exp, p_inta, p_rel;
	logic [4:0] end_exp, start_exp, p_mux;
	logic [4:0] expq[$];
	int num_errors, checks, cycles, nconv, nexp;
	// ==========================
	// design and converter model
	adc_scan_interrupt_control dut (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.inta_o(inta_o), .inta_oe(inta_oe), .pace_tick(pace_tick),
		.result_valid(result_valid), .result_data(result_data), .conv_start(conv_start),
		.mux_pos(mux_pos), .mux_neg(mux_neg), .mux_sense(mux_sense), .gain_sel(gain_sel),
		.mbox_wr(mbox_wr), .mbox_chan(mbox_chan), .mbox_data(mbox_data),
		.new_data_set(new_data_set));
	adc_front_model model (.clock(clock), .rst_b(rst_b), .conv_start(conv_start),
		.mux_pos(mux_pos), .slow(slow), .result_valid(result_valid),
		.result_data(result_data));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// ==========================
	// checking
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// the line rises together with the store that causes it
	function automatic logic raise_ok(input logic stored, input logic [4:0] ch);
		raise_ok = en_exp && stored &&
			(irq_exp == IRQ_PER_CHAN || (irq_exp == IRQ_PER_GROUP && ch == end_exp));
	endfunction
	task automatic final_report();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (rst_b) begin
			if (mbox_wr) begin
				if (expq.size() == 0) begin
					cmp(1, 0, "extra store");
				end else begin
					cmp(mbox_chan, expq.pop_front(), "store channel");
					cmp(mbox_data, {mbox_chan, ~mbox_chan, 6'h25}, "store word");
					cmp(new_data_set, 32'h1 << mbox_chan, "new data flag");
				end
			end
			if (conv_start) begin
				cmp(gain_sel, gains[2*mux_pos+:2], "gain");
				cmp(mux_sense, se_exp, "sense lead");
				if (!se_exp) cmp(mux_neg, mux_pos[3:0], "minus input");
				// the flush convert leaves the pointer where it is
				if (nconv < nexp) begin
					cmp(mux_pos, p_mux == end_exp ? start_exp : p_mux + 5'h1, "next chan");
				end else begin
					cmp(mux_pos, p_mux, "held channel");
				end
				nconv++;
			end
			if (inta_oe && !p_inta) begin
				cmp(raise_ok(mbox_wr, mbox_chan), 1, "raise cause");
				cmp(inta_o, 0, "line level");
			end
			if (!inta_oe && p_inta) cmp(p_rel, 1, "drop cause");
		end
		p_inta <= inta_oe;
		p_mux <= mux_pos;
		p_rel <= reg_wr && reg_addr == OFS_INT && reg_wdata[INT_RELEASE_BIT];
	end
	// ==========================
	// stimulus tasks
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clock);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
	task automatic pace();
		repeat (11) @(posedge clock);
		#1;
		pace_tick = 1'b1;
		@(posedge clock);
		#1;
		pace_tick = 1'b0;
	endtask
	task automatic run(input logic se, input logic [1:0] irq, input logic en,
		input logic [2:0] mode);
		logic [4:0] s;
		logic [15:0] c;
		int n;
		end_exp = 5'($urandom_range(se ? 31 : 15, 0));
		s = 5'($urandom_range(end_exp, 0));
		start_exp = s;
		nexp = end_exp - s + 1;
		nconv = 0;
		se_exp = se;
		irq_exp = irq;
		en_exp = en;
		c = (16'(irq) << CTRL_IRQ_LSB) | (16'(mode) << CTRL_SCAN_LSB) | (16'(se) << CTRL_SE_BIT);
		for (n = s; n <= end_exp; n++) expq.push_back(5'(n));
		wr(OFS_INT, {15'h0000, en});
		wr(OFS_CHAN_RANGE, {3'h0, end_exp, 3'h0, s});
		wr(OFS_CTRL, c);
		rd(OFS_CTRL, rdv);
		cmp(rdv & 16'h370c, c, "control readback");
		wr(OFS_START_CONV, 16'h0001);
		for (n = 0; n < 200 && expq.size() > 0; n++) pace();
		repeat (4) pace();
		cmp(expq.size(), 0, "missing stores");
	endtask
	// host handler: read, disable, release, enable
	task automatic service();
		rd(OFS_INT, rdv);
		cmp(rdv, 16'h0003, "pending read");
		wr(OFS_INT, 16'h0000);
		cmp(inta_oe, 1, "held after disable");
		wr(OFS_INT, 16'h8000);
		wr(OFS_INT, 16'h0001);
		cmp(inta_oe, 0, "released");
		rd(OFS_INT, rdv);
		cmp(rdv, 16'h0001, "pending cleared");
		repeat (20) @(posedge clock);
		cmp(inta_oe, 0, "stays inactive");
	endtask
	// ==========================
	// main sequence
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		pace_tick = 1'b0;
		slow = 1'b0;
		gains = 64'h0;
		se_exp = 1'b1;
		en_exp = 1'b0;
		irq_exp = 2'h0;
		end_exp = 5'h00;
		start_exp = 5'h00;
		nconv = 0;
		nexp = 0;
		cycles = 0;
		void'($urandom(32'h62d8));
		fork
			begin
				repeat (12) @(posedge clock);
				#1;
				rst_b = 1'b1;
				cmp(mux_sense, 1, "reset sense");
				rd(OFS_INT, rdv);
				cmp(rdv, 16'h0000, "reset int");
				rd(OFS_CTRL, rdv);
				cmp(rdv, CTRL_RESET, "reset control");
				rd(8'h3c, rdv);
				cmp(rdv, 16'h0000, "unmapped read");
				for (int i = 0; i < GAIN_REGS; i++) begin
					gains[16*i+:16] = 16'($urandom);
					wr(OFS_GAIN0 + 8'(4*i), gains[16*i+:16]);
				end
				// start refused while scanning is off, so no interrupt either
				wr(OFS_INT, 16'h0001);
				wr(OFS_CTRL, 16'h1000);
				wr(OFS_START_CONV, 16'h0001);
				repeat (3) pace();
				cmp(inta_oe, 0, "no scan no request");
				run(1'b1, IRQ_PER_CHAN, 1'b1, SCAN_BURST_SINGLE);
				cmp(inta_oe, 1, "per channel request");
				service();
				slow = 1'b1;
				run(1'b0, IRQ_PER_GROUP, 1'b1, SCAN_UNI_SINGLE);
				cmp(inta_oe, 1, "per group request");
				service();
				slow = 1'b0;
				run(1'b1, IRQ_PER_CHAN, 1'b0, SCAN_BURST_SINGLE);
				cmp(inta_oe, 0, "disabled board");
				run(1'b0, IRQ_NONE, 1'b1, SCAN_UNI_SINGLE);
				cmp(inta_oe, 0, "irq mode none");
			end
			begin
				// runs take under two thousand cycles; far beyond that means a hang
				wait (cycles > 40000);
				num_errors++;
			end
		join_any
		final_report();
	end
endmodule
